/* core/nerc_pkg.sv */
// Register map, field positions and timing constants of the error report control block
package nerc_pkg;
	// Register offsets in configuration space
	localparam logic [7:0] REPORT_EN_OFFSET  = 8'h40;
	localparam logic [7:0] CONFIG_OFFSET     = 8'h44;
	localparam logic [31:0] REPORT_EN_RESET  = 32'h0000_0000;
	localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
	// Writable bits of each register, reserved bits read as zero
	localparam logic [31:0] REPORT_EN_WMASK  = 32'h0004_3fff;
	localparam logic [31:0] CONFIG_WMASK     = 32'h7bf3_ffff;
	// Report enable fields
	localparam int RE_CORR_ECC   = 0;
	localparam int RE_UNCORR_ECC = 1;
	localparam int RE_CRC0       = 2;
	localparam int RE_SYNC0      = 5;
	localparam int RE_MASTER_AB  = 8;
	localparam int RE_TARGET_AB  = 9;
	localparam int RE_TABLE_WALK = 10;
	localparam int RE_ATOMIC     = 11;
	localparam int RE_WATCHDOG   = 12;
	localparam int RE_DEV_EXCL   = 13;
	localparam int RE_ADDR_PAR   = 18;
	// Configuration fields
	localparam int CF_CORE_ECC_LOG  = 0;
	localparam int CF_CORE_RD_LOG   = 1;
	localparam int CF_FLOOD_UC      = 2;
	localparam int CF_SYNC_GEN_DIS  = 3;
	localparam int CF_SYNC_PROP_DIS = 4;
	localparam int CF_IO_MA_DIS     = 5;
	localparam int CF_CORE_ERR_DIS  = 6;
	localparam int CF_IO_ERR_DIS    = 7;
	localparam int CF_WD_DIS        = 8;
	localparam int CF_WD_CNT_LO     = 9;
	localparam int CF_WD_BASE_LO    = 12;
	localparam int CF_LINK_SEL_LO   = 14;
	localparam int CF_INJ_LANE0     = 16;
	localparam int CF_INJ_LANE1     = 17;
	localparam int CF_FLOOD_WD      = 20;
	localparam int CF_FLOOD_ANY     = 21;
	localparam int CF_ECC_EN        = 22;
	localparam int CF_SYMBOL_ECC    = 23;
	localparam int CF_CFG_RSP_DIS   = 25;
	localparam int CF_TA_RSP_DIS    = 28;
	localparam int CF_MA_RSP_DIS    = 29;
	localparam int CF_FLOOD_PAR     = 30;
	// Watchdog: largest count and time bases
	localparam logic [11:0] WD_MAX_COUNT = 12'hfff;
	localparam int CLOCK_PERIOD_PS  = 8000;
	localparam int BASE_MS_PS       = 1000000000;
	localparam int BASE_US_PS       = 1000000;
	localparam int BASE_NS5_PS      = 5000;
	localparam int BASE_MS_CYCLES   = BASE_MS_PS / CLOCK_PERIOD_PS;
	localparam int BASE_US_CYCLES   = BASE_US_PS / CLOCK_PERIOD_PS;
	localparam int BASE_NS5_CYCLES  = 1;
	localparam logic [1:0] BASE_SEL_MS  = 2'h0;
	localparam logic [1:0] BASE_SEL_US  = 2'h1;
	localparam logic [1:0] BASE_SEL_NS5 = 2'h2;
	localparam int NUM_LINKS = 3;
	typedef enum logic [1:0]
	{
		WD_IDLE  = 2'b00,
		WD_COUNT = 2'b01,
		WD_FIRE  = 2'b10
	} nerc_wd_state_t;
endpackage : nerc_pkg

/* core/nerc_ctrl.sv */
// Error report enables, error handling configuration and watchdog of the northbridge
`timescale 1ns/1ps
module nerc_ctrl
	import nerc_pkg::*;
#(
	parameter int MS_CYCLES = BASE_MS_CYCLES
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Configuration space access
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	// Detected error events, one-cycle pulses
	input  wire logic        corr_ecc_evt,
	input  wire logic        uncorr_ecc_evt,
	input  wire logic [2:0]  link_crc_evt,
	input  wire logic [2:0]  link_sync_evt,
	input  wire logic        master_abort_evt,
	input  wire logic        target_abort_evt,
	input  wire logic        table_walk_evt,
	input  wire logic        atomic_noncoh_evt,
	input  wire logic        atomic_mmio_evt,
	input  wire logic        dev_excl_evt,
	input  wire logic        addr_parity_evt,
	// Outstanding access tracking for the watchdog
	input  wire logic        access_pending,
	// Outputs towards the bank, links and requestor; injection completion input from the links
	output logic             status_en_set,
	output logic [13:0]      mc_report,
	output logic             addr_parity_report,
	output logic             sync_flood,
	output logic             error_rsp,
	output logic             error_rsp_ones,
	output logic             watchdog_complete,
	output logic [2:0]       inject_crc_lane0,
	output logic [2:0]       inject_crc_lane1,
	input  wire logic [2:0]  inject_done
);
	logic [31:0]    report_en_reg;
	logic [31:0]    config_reg;
	logic [11:0]    wd_limit_next;
	logic [31:0]    base_limit_next;
	logic [31:0]    base_cnt_reg;
	logic [11:0]    wd_cnt_reg;
	nerc_wd_state_t wd_state_reg;
	logic           wd_fire;
	logic           wd_tick;
	logic [2:0]     link_onehot;
	logic           any_uncorr;

	assign link_onehot = 3'h1 << config_reg[CF_LINK_SEL_LO +: 2];
	assign wd_fire = (wd_state_reg == WD_FIRE);
	assign any_uncorr = uncorr_ecc_evt | (|link_crc_evt) | master_abort_evt | target_abort_evt
		| table_walk_evt | atomic_noncoh_evt | dev_excl_evt | addr_parity_evt | wd_fire;

	// Report enable register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			report_en_reg <= REPORT_EN_RESET;
		else if (cfg_wr && cfg_addr == REPORT_EN_OFFSET)
			report_en_reg <= cfg_wdata & REPORT_EN_WMASK;
	end

	// Configuration register; injection bits self-clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			config_reg <= CONFIG_RESET;
		else if (cfg_wr && cfg_addr == CONFIG_OFFSET)
			config_reg <= cfg_wdata & CONFIG_WMASK;
		else
		begin
			if (|(inject_done & link_onehot))
			begin
				config_reg[CF_INJ_LANE0] <= 1'b0;
				config_reg[CF_INJ_LANE1] <= 1'b0;
			end
		end
	end

	// Register read
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg_rdata <= 32'h0000_0000;
		else if (cfg_rd)
			cfg_rdata <= (cfg_addr == REPORT_EN_OFFSET) ? report_en_reg :
				(cfg_addr == CONFIG_OFFSET) ? config_reg : 32'h0000_0000;
	end

	// lane corruption on the selected link
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inject_crc_lane0 <= 3'h0;
			inject_crc_lane1 <= 3'h0;
		end
		else
		begin
			inject_crc_lane0 <= config_reg[CF_INJ_LANE0] ? link_onehot : 3'h0;
			inject_crc_lane1 <= config_reg[CF_INJ_LANE1] ? link_onehot : 3'h0;
		end
	end

	// Machine-check report gating
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mc_report     <= 14'h0000;
			status_en_set <= 1'b0;
			addr_parity_report <= 1'b0;
		end
		else
		begin
			status_en_set <= corr_ecc_evt & report_en_reg[RE_CORR_ECC];
			mc_report[0]  <= 1'b0;
			mc_report[1]  <= uncorr_ecc_evt & report_en_reg[RE_UNCORR_ECC];
			mc_report[4:2] <= link_crc_evt & report_en_reg[RE_CRC0 +: NUM_LINKS];
			mc_report[7:5] <= link_sync_evt & report_en_reg[RE_SYNC0 +: NUM_LINKS];
			mc_report[8]  <= master_abort_evt & report_en_reg[RE_MASTER_AB];
			mc_report[9]  <= target_abort_evt & report_en_reg[RE_TARGET_AB];
			mc_report[10] <= table_walk_evt & report_en_reg[RE_TABLE_WALK];
			mc_report[11] <= atomic_noncoh_evt & report_en_reg[RE_ATOMIC];
			mc_report[12] <= wd_fire & report_en_reg[RE_WATCHDOG];
			mc_report[13] <= dev_excl_evt & report_en_reg[RE_DEV_EXCL];
			addr_parity_report <= addr_parity_evt & report_en_reg[RE_ADDR_PAR];
		end
	end

	// Sync flood towards all outgoing links
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sync_flood <= 1'b0;
		else
			// flood sources; report enables never gate a flood
			sync_flood <= ((|link_crc_evt) & ~config_reg[CF_SYNC_GEN_DIS])
				| ((|link_sync_evt) & ~config_reg[CF_SYNC_PROP_DIS])
				| (uncorr_ecc_evt & config_reg[CF_FLOOD_UC])
				| (wd_fire & config_reg[CF_FLOOD_WD])
				| (addr_parity_evt & config_reg[CF_FLOOD_PAR])
				| (any_uncorr & config_reg[CF_FLOOD_ANY]);
	end

	// Error response to requestor
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			error_rsp      <= 1'b0;
			error_rsp_ones <= 1'b0;
		end
		else
		begin
			error_rsp      <= master_abort_evt | target_abort_evt | atomic_mmio_evt | wd_fire;
			error_rsp_ones <= master_abort_evt | target_abort_evt;
		end
	end

	always_comb
	begin
		wd_limit_next = WD_MAX_COUNT >> config_reg[CF_WD_CNT_LO +: 3];
		case (config_reg[CF_WD_BASE_LO +: 2])
			BASE_SEL_MS:  base_limit_next = 32'(MS_CYCLES);
			BASE_SEL_US:  base_limit_next = 32'(BASE_US_CYCLES);
			BASE_SEL_NS5: base_limit_next = 32'(BASE_NS5_CYCLES);
			default:      base_limit_next = 32'(BASE_NS5_CYCLES);
		endcase
	end

	assign wd_tick = (base_cnt_reg + 32'h1 >= base_limit_next);

	// Time base prescaler
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			base_cnt_reg <= 32'h0;
		else if (wd_state_reg != WD_COUNT || wd_tick)
			base_cnt_reg <= 32'h0;
		else
			base_cnt_reg <= base_cnt_reg + 32'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wd_state_reg <= WD_IDLE;
			wd_cnt_reg   <= 12'h000;
		end
		else
		begin
			case (wd_state_reg)
				WD_IDLE:
				begin
					wd_cnt_reg <= 12'h000;
					if (access_pending && !config_reg[CF_WD_DIS])
						wd_state_reg <= WD_COUNT;
				end
				WD_COUNT:
				begin
					if (!access_pending || config_reg[CF_WD_DIS])
						wd_state_reg <= WD_IDLE;
					else if (wd_tick)
					begin
						if (wd_cnt_reg >= wd_limit_next)
							wd_state_reg <= WD_FIRE;
						else
							wd_cnt_reg <= wd_cnt_reg + 12'h001;
					end
				end
				WD_FIRE:
					wd_state_reg <= WD_IDLE;
				default:
					wd_state_reg <= WD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			watchdog_complete <= 1'b0;
		else
			watchdog_complete <= wd_fire;
	end

	// Assertions
	property p_corr_no_mc;
		@(posedge clock) disable iff (!rst_n) corr_ecc_evt |=> !mc_report[0] && (status_en_set == $past(report_en_reg[RE_CORR_ECC]));
	endproperty
	a_corr_no_mc: assert property (p_corr_no_mc) else $error("correctable ecc misreported");

	property p_uncorr;
		@(posedge clock) disable iff (!rst_n) uncorr_ecc_evt && report_en_reg[RE_UNCORR_ECC] |=> mc_report[1];
	endproperty
	a_uncorr: assert property (p_uncorr) else $error("uncorrectable ecc not reported");

	property p_crc_gate;
		@(posedge clock) disable iff (!rst_n) ##1 mc_report[4:2] == ($past(link_crc_evt) & $past(report_en_reg[4:2]));
	endproperty
	a_crc_gate: assert property (p_crc_gate) else $error("crc report gating wrong");

	property p_crc_flood;
		@(posedge clock) disable iff (!rst_n) (|link_crc_evt) && !config_reg[CF_SYNC_GEN_DIS] |=> sync_flood;
	endproperty
	a_crc_flood: assert property (p_crc_flood) else $error("no flood on crc error");

	property p_sync_flood;
		@(posedge clock) disable iff (!rst_n) (|link_sync_evt) && !config_reg[CF_SYNC_PROP_DIS] |=> sync_flood;
	endproperty
	a_sync_flood: assert property (p_sync_flood) else $error("no flood on sync packet");

	property p_abort_rsp;
		@(posedge clock) disable iff (!rst_n) master_abort_evt || target_abort_evt |=> error_rsp && error_rsp_ones;
	endproperty
	a_abort_rsp: assert property (p_abort_rsp) else $error("abort without all-ones response");

	property p_mmio_rsp;
		@(posedge clock) disable iff (!rst_n) atomic_mmio_evt |=> error_rsp;
	endproperty
	a_mmio_rsp: assert property (p_mmio_rsp) else $error("atomic mmio without error response");

	property p_wd_complete;
		@(posedge clock) disable iff (!rst_n) wd_fire |=> watchdog_complete && error_rsp;
	endproperty
	a_wd_complete: assert property (p_wd_complete) else $error("watchdog did not complete access");

	property p_reserved_zero;
		@(posedge clock) disable iff (!rst_n) 1'b1 |-> (config_reg & ~CONFIG_WMASK) == 32'h0 && (report_en_reg & ~REPORT_EN_WMASK) == 32'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_sync_gate;
		@(posedge clock) disable iff (!rst_n) ##1 mc_report[7:5] == ($past(link_sync_evt) & $past(report_en_reg[7:5]));
	endproperty
	a_sync_gate: assert property (p_sync_gate) else $error("sync report gating wrong");

	property p_wd_report;
		@(posedge clock) disable iff (!rst_n) wd_fire |=> mc_report[12] == $past(report_en_reg[RE_WATCHDOG]);
	endproperty
	a_wd_report: assert property (p_wd_report) else $error("watchdog report gating wrong");

	property p_parity_report;
		@(posedge clock) disable iff (!rst_n) addr_parity_evt |=> addr_parity_report == $past(report_en_reg[RE_ADDR_PAR]);
	endproperty
	a_parity_report: assert property (p_parity_report) else $error("parity report gating wrong");

	property p_wd_disabled;
		@(posedge clock) disable iff (!rst_n) config_reg[CF_WD_DIS] |=> !wd_fire;
	endproperty
	a_wd_disabled: assert property (p_wd_disabled) else $error("disabled watchdog fired");

	property p_inject_clear;
		@(posedge clock) disable iff (!rst_n) (|(inject_done & link_onehot)) && !(cfg_wr && cfg_addr == CONFIG_OFFSET)
			|=> !config_reg[CF_INJ_LANE0] && !config_reg[CF_INJ_LANE1];
	endproperty
	a_inject_clear: assert property (p_inject_clear) else $error("injection bits not cleared");

	c_flood:    cover property (@(posedge clock) disable iff (!rst_n) sync_flood);
	c_wd:       cover property (@(posedge clock) disable iff (!rst_n) watchdog_complete);
	c_inject:   cover property (@(posedge clock) disable iff (!rst_n) |inject_crc_lane0);
endmodule : nerc_ctrl

/* tb/nerc_link_model.sv */
// Link-side model that performs requested CRC injections
`timescale 1ns/1ps
module nerc_link_model
#(
	parameter int DELAY = 3
)
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Injection requests and completion
	input  wire logic [2:0] lane0,
	input  wire logic [2:0] lane1,
	output logic      [2:0] done
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 8'h00;
			done    <= 3'h0;
		end
		else
		begin
			done <= 3'h0;
			if ((lane0 | lane1) == 3'h0 || done != 3'h0)
				cnt_reg <= 8'h00;
			else if (cnt_reg == 8'(DELAY))
				done <= lane0 | lane1;
			else
				cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule : nerc_link_model

/* tb/tb.sv */
// Self-checking testbench of the error report control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
	import nerc_pkg::*;
	logic        clock, rst_n, cfg_wr, cfg_rd, corr, uncorr, ma, ta, tw, atn, atm, dev, par, pend;
	logic        st, flood, ersp, ones, wdc, prep;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [2:0]  crc, sync, l0, l1, done;
	logic [13:0] mc;
	int          n_fail, tests_run;

	nerc_ctrl #(.MS_CYCLES(10)) dut_u (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(addr), .cfg_wdata(wdata), .cfg_rdata(rdata), .corr_ecc_evt(corr), .uncorr_ecc_evt(uncorr),
		.link_crc_evt(crc), .link_sync_evt(sync), .master_abort_evt(ma), .target_abort_evt(ta),
		.table_walk_evt(tw), .atomic_noncoh_evt(atn), .atomic_mmio_evt(atm), .dev_excl_evt(dev),
		.addr_parity_evt(par), .access_pending(pend), .status_en_set(st), .mc_report(mc),
		.sync_flood(flood), .error_rsp(ersp), .error_rsp_ones(ones), .watchdog_complete(wdc),
		.inject_crc_lane0(l0), .inject_crc_lane1(l1), .inject_done(done), .addr_parity_report(prep));
	nerc_link_model link_u (.clock(clock), .rst_n(rst_n), .lane0(l0), .lane1(l1), .done(done));

	task automatic finish_test;
	begin
		$display("tests_run %0d n_fail %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask : finish_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clock);
		cfg_wr <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clock);
		cfg_wr <= 1'b0;
		#1;
	end
	endtask : wr

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
	begin
		@(posedge clock);
		cfg_rd <= 1'b1;
		addr   <= a;
		@(posedge clock);
		cfg_rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	end
	endtask : rc

	// Pulses the events of e (mc_report order), parity p and MMIO atomic m for one cycle
	task automatic fire(input logic [13:0] e, input logic p, input logic m);
	begin
		@(posedge clock);
		{dev, atn, tw, ta, ma, sync, crc, uncorr, corr} <= {e[13], e[11:0]};
		par <= p;
		atm <= m;
		@(posedge clock);
		{dev, atn, tw, ta, ma, sync, crc, uncorr, corr} <= 13'h0;
		{par, atm} <= 2'h0;
		#1;
	end
	endtask : fire

	task automatic t_regs;
	begin
		rc("en_rst", REPORT_EN_OFFSET, 32'h0);
		rc("cf_rst", CONFIG_OFFSET, 32'h0);
		wr(REPORT_EN_OFFSET, 32'hffff_ffff);
		wr(CONFIG_OFFSET, 32'hffff_ffff);
		rc("en_all", REPORT_EN_OFFSET, REPORT_EN_WMASK);
		rc("cf_all", CONFIG_OFFSET, CONFIG_WMASK);
		rc("unmapped", 8'h48, 32'h0);
		wr(REPORT_EN_OFFSET, 32'h0);
		wr(CONFIG_OFFSET, 32'h0);
		rc("cf_clr", CONFIG_OFFSET, 32'h0);
		$display("test regs done");
	end
	endtask : t_regs

	task automatic t_report;
	begin
		for (int i = 0; i < 14; i++)
		begin
			if (i != 12)
			begin
				wr(REPORT_EN_OFFSET, 32'h1 << i);
				fire(14'h2fff, 1'b0, 1'b0);
				`CHK("mc_gate", (i == 0) ? 14'h0 : 14'(1 << i), mc)
				`CHK("st_set", 1'(i == 0), st)
			end
		end
		wr(REPORT_EN_OFFSET, 32'h0004_0000);
		fire(14'h0, 1'b1, 1'b0);
		`CHK("par_on", 2'b10, {prep, flood})
		wr(REPORT_EN_OFFSET, 32'h0);
		fire(14'h0, 1'b1, 1'b0);
		`CHK("par_off", 2'b00, {prep, flood})
		$display("test report done");
	end
	endtask : t_report

	task automatic t_flood;
	begin
		for (int n = 0; n < 3; n++)
		begin
			fire(14'(4 << n), 1'b0, 1'b0);
			`CHK("crc_flood", 15'h4000, {flood, mc})
			fire(14'(32 << n), 1'b0, 1'b0);
			`CHK("sync_flood", 15'h4000, {flood, mc})
		end
		fire(14'h0100, 1'b0, 1'b0);
		`CHK("ma_rsp", 16'h0003, {mc, ersp, ones})
		fire(14'h0200, 1'b0, 1'b0);
		`CHK("ta_rsp", 16'h0003, {mc, ersp, ones})
		fire(14'h0, 1'b0, 1'b1);
		`CHK("mmio_rsp", 16'h0002, {mc, ersp, ones})
		wr(CONFIG_OFFSET, 32'h0000_0008);
		fire(14'h0004, 1'b0, 1'b0);
		`CHK("crc_gen_dis", 1'b0, flood)
		wr(CONFIG_OFFSET, 32'h0000_0004);
		fire(14'h0002, 1'b0, 1'b0);
		`CHK("uc_flood", 15'h4000, {flood, mc})
		wr(CONFIG_OFFSET, 32'h0020_0000);
		fire(14'h0400, 1'b0, 1'b0);
		`CHK("any_flood", 15'h4000, {flood, mc})
		wr(CONFIG_OFFSET, 32'h4000_0000);
		fire(14'h0, 1'b1, 1'b0);
		`CHK("par_flood", 2'b01, {prep, flood})
		wr(CONFIG_OFFSET, 32'h0);
		fire(14'h0002, 1'b0, 1'b0);
		`CHK("uc_quiet", 1'b0, flood)
		$display("test flood done");
	end
	endtask : t_flood

	task automatic wd(input logic [31:0] cf, input logic [31:0] en, input int lo);
		int   k;
		logic seen, rs, m;
	begin
		wr(REPORT_EN_OFFSET, en);
		wr(CONFIG_OFFSET, cf);
		@(posedge clock);
		pend <= 1'b1;
		seen = 1'b0;
		for (k = 0; k < 400 && !seen; k++)
		begin
			@(posedge clock);
			#1;
			seen = wdc;
			rs   = ersp;
			m    = mc[12];
		end
		@(posedge clock);
		pend <= 1'b0;
		`CHK("wd_fire", 1'(lo != 0), seen)
		if (lo != 0)
		begin
			`CHK("wd_span", 1'b1, 1'(k >= lo && k <= lo + 4))
			`CHK("wd_rsp", {1'b1, en[12]}, {rs, m})
		end
		repeat (3) @(posedge clock);
	end
	endtask : wd

	task automatic t_watchdog;
	begin
		wd(32'h0000_2e00, 32'h0, 32);
		wd(32'h0000_0e00, 32'h0, 320);
		wd(32'h0000_2c00, 32'h1000, 64);
		wd(32'h0000_2f00, 32'h1000, 0);
		$display("test watchdog done");
	end
	endtask : t_watchdog

	task automatic inj(input logic [31:0] cf, input logic [5:0] e);
	begin
		wr(CONFIG_OFFSET, cf);
		@(posedge clock);
		#1;
		`CHK("inj_on", e, {l1, l0})
		for (int k = 0; k < 30 && {l1, l0} != 6'h0; k++)
		begin
			@(posedge clock);
			#1;
		end
		`CHK("inj_off", 6'h00, {l1, l0})
		rc("inj_clr", CONFIG_OFFSET, cf & 32'h0000_c000);
	end
	endtask : inj

	task automatic t_inject;
	begin
		inj(32'h0001_4000, 6'h02);
		inj(32'h0002_8000, 6'h20);
		$display("test inject done");
	end
	endtask : t_inject

	task automatic t_reset;
	begin
		wr(REPORT_EN_OFFSET, 32'hffff_ffff);
		wr(CONFIG_OFFSET, 32'hffff_ffff);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rc("en_rst2", REPORT_EN_OFFSET, 32'h0);
		rc("cf_rst2", CONFIG_OFFSET, 32'h0);
		$display("test reset done");
	end
	endtask : t_reset

	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		$display("unexpected timeout");
		finish_test();
	end

	initial
	begin
		{rst_n, cfg_wr, cfg_rd, pend, par, atm} = 6'h0;
		{dev, atn, tw, ta, ma, sync, crc, uncorr, corr} = 13'h0;
		addr = 8'h0;
		wdata = 32'h0;
		n_fail = 0;
		tests_run = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_report();
		t_flood();
		t_watchdog();
		t_inject();
		t_reset();
		finish_test();
	end
endmodule : tb
